//--- shared/prt_pkg.sv
// Constants for the prescaled reload timer set
package prt_pkg;
  localparam logic [7:0]  ADR_PS_CTRL  = 8'h00;
  localparam logic [7:0]  ADR_T1_CTRL  = 8'h04;
  localparam logic [7:0]  ADR_T2_CTRL  = 8'h08;
  localparam logic [7:0]  ADR_T3_CTRL  = 8'h0C;
  localparam logic [7:0]  ADR_AUX_CTRL = 8'h10;
  localparam logic [7:0]  ADR_PS_RLD   = 8'h14;
  localparam logic [7:0]  ADR_T1_RLD   = 8'h18;
  localparam logic [7:0]  ADR_T1_CNT   = 8'h24;
  localparam logic [7:0]  ADR_IRQ_STS  = 8'h30;
  localparam logic [7:0]  ADR_IRQ_MSK  = 8'h34;
  localparam logic [7:0]  ADR_PS_CNT   = 8'h38;
  localparam logic [7:0]  ADR_WD_STS   = 8'h3C;
  localparam logic [7:0]  ADR_STEP     = 8'h04;
  localparam int          BIT_RUN_PS   = 0;
  localparam int          BIT_SRC_PS   = 1;
  localparam int          BIT_RUN_T    = 2;
  localparam int          BIT_RUN_T3   = 1;
  localparam int          BIT_SRC_T3   = 0;
  localparam int          BIT_PIN_SEL  = 3;
  localparam int          BIT_OUT_EN   = 3;
  localparam int          BIT_EDGE     = 2;
  localparam logic [1:0]  SRC_PWM      = 2'h0;
  localparam logic [1:0]  SRC_PS       = 2'h1;
  localparam logic [1:0]  SRC_SYSTEM_TICK     = 2'h2;
  localparam logic [1:0]  SRC_ALT      = 2'h3;
  localparam logic [1:0]  RST_PS_CTRL  = 2'h0;
  localparam logic [3:0]  RST_CTRL     = 4'h0;
  localparam logic [7:0]  RST_RLD      = 8'hFF;
  localparam logic [1:0]  DIV4_LAST    = 2'h3;
  localparam logic [15:0] WD_LAST      = 16'hFFFF;
endpackage

//--- tb/prescaled_reload_timer_set_tb_top.sv
// Self-checking bench for the prescaled reload timer set
`timescale 1ns/1ps
module prescaled_reload_timer_set_tb_top;
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] dat_w    = 32'h0;
  logic        itk      = 1'b0;
  logic        stk      = 1'b0;
  logic        wclr     = 1'b0;
  logic        go       = 1'b0;
  logic [1:0]  line     = 2'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        pwm;
  logic        cpin;
  logic        osc;
  logic        cnt0_o;
  logic        car_o;
  logic        wdf_o;
  logic        wdr_o;
  logic        irq_o;
  logic [31:0] q;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          i;
  always #10 clk_i = ~clk_i;
  prt_timer_set u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
    .dat_o(dat_o), .ack_o(ack_o), .instruction_tick_i(itk),
    .system_tick_i(stk), .pwm_signal_i(pwm), .count_pin_input_i(cpin),
    .oscillator_input_i(osc), .watchdog_clear_i(wclr),
    .count_pin_zero_o(cnt0_o), .carrier_pin_o(car_o),
    .watchdog_flag_o(wdf_o), .watchdog_reset_o(wdr_o), .irq_o(irq_o));
  prt_pin_model u_pins (.clk_i(clk_i), .resetn_i(resetn_i), .go_i(go),
    .line_i(line), .pwm_signal_o(pwm), .count_pin_o(cpin), .osc_o(osc));
  task tally_and_finish();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Wait for ack, bounded; take data at the ack edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s);
    int k;
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= s;
    k = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      k++;
      if (k > 16) begin
        n_errors++;
        tally_and_finish();
      end
      @(posedge clk_i);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'h0);
    chk(nm, q, e);
  endtask
  // n-cycle pulses: 0 instruction tick, 1 system tick
  task tick(input int which, input int n);
    if (which == 0) itk <= 1'b1;
    else stk <= 1'b1;
    repeat (n) @(posedge clk_i);
    itk <= 1'b0;
    stk <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task pin_pulse(input logic [1:0] l);
    line <= l;
    go   <= 1'b1;
    repeat (2) @(posedge clk_i);
    go <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd("t1_ctrl", prt_pkg::ADR_T1_CTRL, 32'h0);
    rd("t1_cnt0", prt_pkg::ADR_T1_CNT, 32'hFF);
    rd("status", prt_pkg::ADR_IRQ_STS, 32'h0);
    rd("unmapped", 8'hFC, 32'h0);
    wb(1'b1, prt_pkg::ADR_T1_RLD, 32'h3, 4'h1);
    rd("part_wr", prt_pkg::ADR_T1_CNT, 32'hFF);
    wr(prt_pkg::ADR_T1_RLD, 32'h3);
    wr(prt_pkg::ADR_T1_CTRL, 32'h6);
    tick(1, 2);
    rd("t1_cnt", prt_pkg::ADR_T1_CNT, 32'h1);
    tick(1, 1);
    rd("status", prt_pkg::ADR_IRQ_STS, 32'h0);
    tick(1, 1);
    rd("t1_cnt", prt_pkg::ADR_T1_CNT, 32'h3);
    rd("status", prt_pkg::ADR_IRQ_STS, 32'h1);
    chk("cnt_pin", cnt0_o, 32'h1);
    wr(prt_pkg::ADR_T1_CTRL, 32'h2);
    tick(1, 3);
    rd("t1_hold", prt_pkg::ADR_T1_CNT, 32'h3);
    chk("irq_off", irq_o, 32'h0);
    wr(prt_pkg::ADR_IRQ_MSK, 32'h7);
    chk("irq_on", irq_o, 32'h1);
    wr(prt_pkg::ADR_IRQ_STS, 32'h1);
    rd("status", prt_pkg::ADR_IRQ_STS, 32'h0);
    chk("irq_clr", irq_o, 32'h0);
    wr(prt_pkg::ADR_PS_RLD, 32'h0);
    wr(prt_pkg::ADR_PS_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(prt_pkg::ADR_T1_CTRL, 32'h0);
      wr(prt_pkg::ADR_T1_RLD, 32'h1);
      wr(prt_pkg::ADR_T1_CTRL, 32'h4 | i);
      case (i)
        0: pin_pulse(2'h0);
        1: tick(0, 1);
        2: tick(1, 1);
        default: pin_pulse(2'h1);
      endcase
      rd("t1_src", prt_pkg::ADR_T1_CNT, 32'h0);
    end
    wr(prt_pkg::ADR_PS_CTRL, 32'h0);
    wr(prt_pkg::ADR_PS_CTRL, 32'h3);
    wr(prt_pkg::ADR_T1_CTRL, 32'h0);
    wr(prt_pkg::ADR_T1_RLD, 32'h3);
    wr(prt_pkg::ADR_T1_CTRL, 32'h5);
    tick(0, 4);
    rd("div4", prt_pkg::ADR_T1_CNT, 32'h2);
    tick(0, 3);
    rd("div4", prt_pkg::ADR_T1_CNT, 32'h2);
    wr(prt_pkg::ADR_PS_CTRL, 32'h0);
    wr(prt_pkg::ADR_PS_CTRL, 32'h3);
    tick(0, 3);
    rd("ps_init", prt_pkg::ADR_T1_CNT, 32'h2);
    wr(prt_pkg::ADR_IRQ_STS, 32'h7);
    wr(prt_pkg::ADR_T1_CTRL, 32'h2);
    wr(prt_pkg::ADR_T1_RLD, 32'h0);
    wr(prt_pkg::ADR_T1_RLD + prt_pkg::ADR_STEP, 32'h1);
    wr(prt_pkg::ADR_T1_CTRL + prt_pkg::ADR_STEP, 32'h7);
    wr(prt_pkg::ADR_T1_CTRL, 32'h6);
    tick(1, 1);
    rd("t2_cnt", prt_pkg::ADR_T1_CNT + prt_pkg::ADR_STEP, 32'h0);
    tick(1, 1);
    rd("t2_udf", prt_pkg::ADR_IRQ_STS, 32'h3);
    wr(prt_pkg::ADR_IRQ_STS, 32'h7);
    wr(prt_pkg::ADR_T1_CTRL, 32'h2);
    wr(prt_pkg::ADR_T1_RLD + 2 * prt_pkg::ADR_STEP, 32'h0);
    wr(prt_pkg::ADR_T3_CTRL, 32'hA);
    pin_pulse(2'h2);
    rd("t3_udf", prt_pkg::ADR_IRQ_STS, 32'h4);
    chk("carrier", car_o, 32'h1);
    wr(prt_pkg::ADR_AUX_CTRL, 32'h1);
    wr(prt_pkg::ADR_T1_RLD, 32'h2);
    wr(prt_pkg::ADR_T1_CTRL, 32'h6);
    pin_pulse(2'h2);
    rd("t1_by_t3", prt_pkg::ADR_T1_CNT, 32'h1);
    chk("wd_early", wdf_o, 32'h0);
    itk <= 1'b1;
    i = 0;
    @(posedge clk_i);
    while (wdf_o !== 1'b1 && i < 70000) begin
      i++;
      @(posedge clk_i);
    end
    itk <= 1'b0;
    chk("wd_span", (i > 65500 && i < 65540), 32'h1);
    chk("wd_rst", wdr_o, 32'h0);
    rd("wd_sts", prt_pkg::ADR_WD_STS, 32'h1);
    wclr <= 1'b1;
    @(posedge clk_i);
    wclr <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("wd_clr", wdf_o, 32'h0);
    tally_and_finish();
  end
endmodule

//--- tb/prt_pin_model.sv
// Pin-side model driving the PWM, count pin and oscillator lines
`timescale 1ns/1ps
module prt_pin_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       go_i,
  input  wire logic [1:0] line_i,
  output logic            pwm_signal_o,
  output logic            count_pin_o,
  output logic            osc_o
);
  logic [2:0] hi_reg;
  logic [2:0] hi_next;
  // lines move only after an edge, high while go is held
  always_comb begin
    hi_next = 3'h0;
    if (go_i) begin
      hi_next = 3'h1 << line_i;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_reg <= 3'h0;
    end else begin
      hi_reg <= hi_next;
    end
  end
  assign pwm_signal_o = hi_reg[0];
  assign count_pin_o  = hi_reg[1];
  assign osc_o        = hi_reg[2];
endmodule

//--- verilog/prt_timer_set.sv
// Prescaler, three reload timers and watchdog behind a Wishbone slave
// Operation
// - Timer counts down from n, underflows after n+1 counts, flags, reloads.
// - 8-bit prescaler divides instruction tick or tick/4 by 1..256.
// - Timer 1 counts PWM, prescaler, system tick or pin input.
// - Timer 2 counts PWM, timer 1 underflow, prescaler or system tick.
// - Timer 3 counts oscillator or half prescaler, drives carrier pin.
// - Watchdog divides instruction tick by 65536, resets after two cycles.
// - Watchdog runs from reset, untouched by timer control registers.
// - Each of timers 1 to 3 owns its own interrupt flag.
// - Prescaler source bit: 0 undivided tick, 1 tick divided by four.
// - Prescaler run bit low stops and initializes the prescaler.
// - Timer run bit low holds count, a reload write loads it; high resumes counting.
// - Timer 1 select 00 PWM, 01 prescaler, 10 system tick, 11 pin.
`timescale 1ns/1ps
module prt_timer_set (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        instruction_tick_i,
  input  wire logic        system_tick_i,
  input  wire logic        pwm_signal_i,
  input  wire logic        count_pin_input_i,
  input  wire logic        oscillator_input_i,
  input  wire logic        watchdog_clear_i,
  output logic             count_pin_zero_o,
  output logic             carrier_pin_o,
  output logic             watchdog_flag_o,
  output logic             watchdog_reset_o,
  output logic             irq_o
);
  logic [1:0]  ps_ctrl_reg, ps_ctrl_next;
  logic [3:0]  ctrl_reg [3];
  logic [3:0]  ctrl_next [3];
  logic [3:0]  aux_reg, aux_next;
  logic [7:0]  ps_rld_reg, ps_rld_next;
  logic [7:0]  ps_cnt_reg, ps_cnt_next;
  logic [1:0]  div4_reg, div4_next;
  logic        half_reg, half_next;
  logic [2:0]  sts_reg, sts_next;
  logic [2:0]  msk_reg, msk_next;
  logic [31:0] dat_reg, dat_next;
  logic        ack_reg;
  logic        pwm_d_reg, pin_d_reg, osc_d_reg;
  logic        cp0_reg, cp0_next, cp1_reg, cp1_next;
  logic [15:0] wd_cnt_reg, wd_cnt_next;
  logic        wd_flag_reg, wd_flag_next;
  logic        wd_rst_reg, wd_rst_next;
  logic [7:0]  t_cnt [3];
  logic        t_tick [3];
  logic        t_udf [3];
  logic        t_run [3];
  logic        wr, div4_tick, ps_src, prescaler_out, ps_half;
  logic        pwm_rise, pin_edge, osc_rise, wd_wrap;
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Write is taken on the edge where the master sees ack
  assign wr = cyc_i & stb_i & we_i & ack_reg & (&sel_i);

  function automatic logic wr_at(input logic [7:0] a);
    return wr && adr_i == a;
  endfunction

  assign pwm_rise = pwm_signal_i & ~pwm_d_reg;
  assign osc_rise = oscillator_input_i & ~osc_d_reg;
  assign pin_edge = aux_reg[prt_pkg::BIT_EDGE] ?
                    (count_pin_input_i & ~pin_d_reg) :
                    (~count_pin_input_i & pin_d_reg);

  assign div4_tick = instruction_tick_i & (div4_reg == prt_pkg::DIV4_LAST);
  assign ps_src = ps_ctrl_reg[prt_pkg::BIT_SRC_PS] ? div4_tick
                                                   : instruction_tick_i;
  assign prescaler_out = ps_ctrl_reg[prt_pkg::BIT_RUN_PS] & ps_src &
                         (ps_cnt_reg == 8'h00);
  assign ps_half = prescaler_out & half_reg;

  assign t_tick[2] = ctrl_reg[2][prt_pkg::BIT_SRC_T3] ? ps_half : osc_rise;
  assign t_run[2]  = ctrl_reg[2][prt_pkg::BIT_RUN_T3];
  assign t_run[0]  = ctrl_reg[0][prt_pkg::BIT_RUN_T];
  assign t_run[1]  = ctrl_reg[1][prt_pkg::BIT_RUN_T];

  // select decode, shared by timers 1 and 2
  function automatic logic pick_src(input logic [1:0] s,
                                    input logic [3:0] srcs);
    return srcs[s];
  endfunction
  // timer 1 source, timer 3 underflow when aux bit 0 is set
  assign t_tick[0] = aux_reg[0] ? t_udf[2] :
                     pick_src(ctrl_reg[0][1:0], {pin_edge, system_tick_i,
                                                 prescaler_out, pwm_rise});
  // timer 2 source, timer 1 underflow at select 11, timer 3 underflow when aux bit 1 is set
  assign t_tick[1] = aux_reg[1] ? t_udf[2] :
                     pick_src(ctrl_reg[1][1:0], {t_udf[0], system_tick_i,
                                                 prescaler_out, pwm_rise});
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tmr
      logic [7:0] cnt_reg, cnt_next, rld_reg, rld_next;
      logic [7:0] a_rld;
      assign a_rld = prt_pkg::ADR_T1_RLD + 8'(gi * 4);
      assign t_cnt[gi] = cnt_reg;
      assign t_udf[gi] = t_run[gi] & t_tick[gi] & (cnt_reg == 8'h00);
      always_comb begin
        rld_next = rld_reg;
        cnt_next = cnt_reg;
        if (wr_at(a_rld)) begin
          rld_next = dat_i[7:0];
        end
        if (t_udf[gi]) begin
          cnt_next = rld_reg;
        end else if (t_run[gi] & t_tick[gi]) begin
          cnt_next = cnt_reg - 8'h01;
        end else if (!t_run[gi] && wr_at(a_rld)) begin
          cnt_next = dat_i[7:0];
        end
      end
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_reg <= prt_pkg::RST_RLD;
          rld_reg <= prt_pkg::RST_RLD;
        end else begin
          cnt_reg <= cnt_next;
          rld_reg <= rld_next;
        end
      end
    end
  endgenerate

  // Control, prescaler, pins, watchdog, interrupts and bus
  always_comb begin
    ps_ctrl_next = ps_ctrl_reg;
    aux_next     = aux_reg;
    ps_rld_next  = ps_rld_reg;
    msk_next     = msk_reg;
    for (int i = 0; i < 3; i++) begin
      ctrl_next[i] = ctrl_reg[i];
      if (wr_at(prt_pkg::ADR_T1_CTRL + 8'(i * 4))) begin
        ctrl_next[i] = dat_i[3:0];
      end
    end
    if (wr_at(prt_pkg::ADR_PS_CTRL)) begin
      ps_ctrl_next = dat_i[1:0];
    end
    if (wr_at(prt_pkg::ADR_AUX_CTRL)) begin
      aux_next = dat_i[3:0];
    end
    if (wr_at(prt_pkg::ADR_PS_RLD)) begin
      ps_rld_next = dat_i[7:0];
    end
    if (wr_at(prt_pkg::ADR_IRQ_MSK)) begin
      msk_next = dat_i[2:0];
    end
    div4_next   = instruction_tick_i ? div4_reg + 2'h1 : div4_reg;
    ps_cnt_next = ps_cnt_reg;
    half_next   = half_reg;
    if (!ps_ctrl_reg[prt_pkg::BIT_RUN_PS]) begin
      ps_cnt_next = ps_rld_reg;
      div4_next   = 2'h0;
      half_next   = 1'b0;
    end else if (prescaler_out) begin
      ps_cnt_next = ps_rld_reg;
      half_next   = ~half_reg;
    end else if (ps_src) begin
      ps_cnt_next = ps_cnt_reg - 8'h01;
    end
    // Pins toggle so each output period spans two underflows
    cp0_next = cp0_reg ^ (ctrl_reg[1][prt_pkg::BIT_PIN_SEL] ? t_udf[1]
                                                             : t_udf[0]);
    cp1_next = cp1_reg ^ t_udf[2];
    // sticky flags, set beats the write-one clear
    sts_next = sts_reg;
    if (wr_at(prt_pkg::ADR_IRQ_STS)) begin
      sts_next = sts_reg & ~dat_i[2:0];
    end
    sts_next = sts_next | {t_udf[2], t_udf[1], t_udf[0]};
    // free running watchdog, no control register reaches it
    wd_cnt_next  = instruction_tick_i ? wd_cnt_reg + 16'h0001 : wd_cnt_reg;
    // flag on first wrap, reset on second
    wd_flag_next = watchdog_clear_i ? 1'b0 : wd_flag_reg;
    wd_rst_next  = wd_wrap & wd_flag_reg;
    if (wd_wrap) begin
      wd_flag_next = 1'b1;
    end
    // Read mux; unmapped words read as zero
    dat_next = 32'h0000_0000;
    unique case (adr_i)
      prt_pkg::ADR_PS_CTRL:  dat_next[1:0] = ps_ctrl_reg;
      prt_pkg::ADR_T1_CTRL:  dat_next[3:0] = ctrl_reg[0];
      prt_pkg::ADR_T1_CTRL + prt_pkg::ADR_STEP:
        dat_next[3:0] = ctrl_reg[1];
      prt_pkg::ADR_T3_CTRL:  dat_next[3:0] = ctrl_reg[2];
      prt_pkg::ADR_AUX_CTRL: dat_next[3:0] = aux_reg;
      prt_pkg::ADR_PS_RLD:   dat_next[7:0] = ps_rld_reg;
      prt_pkg::ADR_T1_CNT:   dat_next[7:0] = t_cnt[0];
      prt_pkg::ADR_T1_CNT + prt_pkg::ADR_STEP:
        dat_next[7:0] = t_cnt[1];
      prt_pkg::ADR_T1_CNT + 8'h08: dat_next[7:0] = t_cnt[2];
      prt_pkg::ADR_IRQ_STS:  dat_next[2:0] = sts_reg;
      prt_pkg::ADR_IRQ_MSK:  dat_next[2:0] = msk_reg;
      prt_pkg::ADR_PS_CNT:   dat_next[7:0] = ps_cnt_reg;
      prt_pkg::ADR_WD_STS:   dat_next[0]   = wd_flag_reg;
      default:               dat_next      = 32'h0000_0000;
    endcase
  end

  assign wd_wrap = instruction_tick_i & (wd_cnt_reg == prt_pkg::WD_LAST);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ps_ctrl_reg <= prt_pkg::RST_PS_CTRL;
      for (int i = 0; i < 3; i++) begin
        ctrl_reg[i] <= prt_pkg::RST_CTRL;
      end
      aux_reg     <= prt_pkg::RST_CTRL;
      ps_rld_reg  <= prt_pkg::RST_RLD;
      ps_cnt_reg  <= prt_pkg::RST_RLD;
      div4_reg    <= 2'h0;
      half_reg    <= 1'b0;
      sts_reg     <= 3'h0;
      msk_reg     <= 3'h0;
      dat_reg     <= 32'h0000_0000;
      ack_reg     <= 1'b0;
      pwm_d_reg   <= 1'b0;
      pin_d_reg   <= 1'b0;
      osc_d_reg   <= 1'b0;
      cp0_reg     <= 1'b0;
      cp1_reg     <= 1'b0;
      wd_cnt_reg  <= 16'h0000;
      wd_flag_reg <= 1'b0;
      wd_rst_reg  <= 1'b0;
    end else begin
      ps_ctrl_reg <= ps_ctrl_next;
      for (int i = 0; i < 3; i++) begin
        ctrl_reg[i] <= ctrl_next[i];
      end
      aux_reg     <= aux_next;
      ps_rld_reg  <= ps_rld_next;
      ps_cnt_reg  <= ps_cnt_next;
      div4_reg    <= div4_next;
      half_reg    <= half_next;
      sts_reg     <= sts_next;
      msk_reg     <= msk_next;
      dat_reg     <= dat_next;
      ack_reg     <= cyc_i & stb_i & ~ack_reg;
      pwm_d_reg   <= pwm_signal_i;
      pin_d_reg   <= count_pin_input_i;
      osc_d_reg   <= oscillator_input_i;
      cp0_reg     <= cp0_next;
      cp1_reg     <= cp1_next;
      wd_cnt_reg  <= wd_cnt_next;
      wd_flag_reg <= wd_flag_next;
      wd_rst_reg  <= wd_rst_next;
    end
  end

  assign dat_o            = dat_reg;
  assign ack_o            = ack_reg;
  assign count_pin_zero_o = cp0_reg;
  assign carrier_pin_o    = cp1_reg & ctrl_reg[2][prt_pkg::BIT_OUT_EN];
  assign watchdog_flag_o  = wd_flag_reg;
  assign watchdog_reset_o = wd_rst_reg;
  assign irq_o            = |(sts_reg & msk_reg);

  property p_reload;
    t_udf[0] |=> t_cnt[0] == $past(g_tmr[0].rld_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("t1 no reload");
  property p_dec;
    t_run[1] && t_tick[1] && t_cnt[1] != 8'h00 |=>
      t_cnt[1] == $past(t_cnt[1]) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("t2 no decrement");
  property p_hold;
    !t_run[2] && !wr |=> t_cnt[2] == $past(t_cnt[2]);
  endproperty
  a_hold: assert property (p_hold) else $error("t3 count moved");
  property p_ps_init;
    !ps_ctrl_reg[0] ##1 !ps_ctrl_reg[0] |-> ps_cnt_reg == $past(ps_rld_reg);
  endproperty
  a_ps_init: assert property (p_ps_init) else $error("ps not reset");
  property p_flag;
    t_udf[1] |=> sts_reg[1];
  endproperty
  a_flag: assert property (p_flag) else $error("t2 flag not set");
  property p_chain;
    ctrl_reg[1][1:0] == 2'h3 && !aux_reg[1] |-> t_tick[1] == t_udf[0];
  endproperty
  a_chain: assert property (p_chain) else $error("t2 not chained");
  property p_one;
    t_udf[0] |=> !t_udf[0] || t_tick[0];
  endproperty
  a_one: assert property (p_one) else $error("udf too long");
  property p_wd;
    wd_wrap && wd_flag_reg |=> watchdog_reset_o ##1 !watchdog_reset_o;
  endproperty
  a_wd: assert property (p_wd) else $error("no wd reset");
  property p_wd_run;
    instruction_tick_i |=> wd_cnt_reg == $past(wd_cnt_reg) + 16'h0001;
  endproperty
  a_wd_run: assert property (p_wd_run) else $error("wd stalled");
  property p_src1;
    ctrl_reg[0][1:0] == 2'h1 && !aux_reg[0] |-> t_tick[0] == prescaler_out;
  endproperty
  a_src1: assert property (p_src1) else $error("t1 select wrong");
endmodule
